// >>> logic/fpio_consts.svh
/*
 * Constants of the four-port parallel I/O block: register addresses,
 * reset values and field positions.
 * Assumes it is included by the design modules only.
 */
`ifndef FPIO_CONSTS_SVH
`define FPIO_CONSTS_SVH

// Register addresses on the core's special function bus
`define FPIO_ADDR_PORT_ZERO   8'h80
`define FPIO_ADDR_PORT_ONE    8'h90
`define FPIO_ADDR_PORT_TWO    8'hA0
`define FPIO_ADDR_PORT_THREE  8'hB0

// Reset values of the four latches
`define FPIO_RST_PORT_ZERO    8'hFF
`define FPIO_RST_PORT_ONE     8'hFF
`define FPIO_RST_PORT_TWO     8'hFF
`define FPIO_RST_PORT_THREE   8'hFF

// Value returned for an unmapped read
`define FPIO_RDATA_NONE       8'h00

// Port one alternate pin positions
`define FPIO_P1_TIMER_TWO_CNT 0
`define FPIO_P1_TIMER_TWO_TRG 1
`define FPIO_P1_SPI_SEL       5

// Port three alternate pin positions
`define FPIO_P3_UART_RX       0
`define FPIO_P3_UART_TX       1
`define FPIO_P3_EXT_INT_ZERO  2
`define FPIO_P3_EXT_INT_ONE   3
`define FPIO_P3_TIMER_ZERO    4
`define FPIO_P3_TIMER_ONE     5
`define FPIO_P3_WR_STROBE     6
`define FPIO_P3_RD_STROBE     7

`endif

// >>> logic/fpio_latch8.sv
/*
 * One 8-bit port latch written from the special function bus.
 * Assumes the write strobe is synchronous to ref_clk_in.
 */
`timescale 1ns/1ns
`include "fpio_consts.svh"

module fpio_latch8
    import fpio_pkg::*;
#(
    parameter logic [7:0] ADDR      = 8'h80,
    parameter logic [7:0] RST_VALUE = 8'hFF
) (
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       sys_rst_in,
    // Write port
    input  wire logic [7:0] sfr_addr_in,
    input  wire logic       sfr_wr_in,
    input  wire logic [7:0] sfr_wdata_in,
    // Latch contents
    output logic      [7:0] latch_out
);

    fpio_latch_state_t state_reg;
    fpio_latch_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (sfr_wr_in && (sfr_addr_in == ADDR)) begin
            state_next.latch = sfr_wdata_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state_reg.latch <= RST_VALUE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign latch_out = state_reg.latch;

endmodule : fpio_latch8

// >>> logic/fpio_pkg.sv
/*
 * Types of the four-port parallel I/O block.
 * Assumes fpio_consts.svh is on the include path.
 */
package fpio_pkg;

    // Phase of an external memory cycle as announced by the core
    typedef enum logic [1:0] {
        FPIO_PH_IDLE,
        FPIO_PH_ADDR,
        FPIO_PH_WDATA,
        FPIO_PH_RDATA
    } fpio_phase_t;

    // State of one port latch
    typedef struct packed {
        logic [7:0] latch;
    } fpio_latch_state_t;

    // State of the port block
    typedef struct packed {
        logic [7:0] p0_out;
        logic [7:0] p0_oe;
        logic [7:0] p0_rdata;
        logic [7:0] p2_out;
        logic [7:0] p2_oe;
        logic [7:0] p3_out;
        logic [7:0] p3_oe;
        logic [7:0] analog_sel;
        logic [7:0] sfr_rdata;
        logic       t2_count;
        logic       t2_trigger;
        logic       spi_sel_n;
        logic       uart_rx;
        logic       ext_int_zero;
        logic       ext_int_one;
        logic       t0_count;
        logic       t1_count;
    } fpio_state_t;

endpackage : fpio_pkg

// >>> logic/fpio_ports.sv
/*
 * Four 8-bit parallel ports of the microcontroller: latches, pin drivers,
 * external memory multiplexing and alternate pin functions.
 * Assumes the core drives the special function bus and the memory phase
 * synchronously to ref_clk_in; pull-ups on ports two and three and the
 * external pull-up of port zero are resolved outside from the enables.
 */
// Summary of operation
// (RQ1) Port zero open-drain, latch at 80h
// (RQ2) Port zero latch one leaves pin floating
// (RQ3) Port zero multiplexes low address, then data
// (RQ4) Port zero bus drives ones strongly
// (RQ5) Port one input only, latch 90h
// (RQ6) Port one resets analog; zero selects digital
// (RQ7) Port one bits: timer two, SPI select
// (RQ8) Port two pulled-up, latch A0h, one inputs
// (RQ9) Port two carries high/middle address bytes
// (RQ10) Port three pulled-up, latch B0h, one inputs
// (RQ11) Port three bits zero/one: UART
// (RQ12) Port three: interrupts and timer inputs
// (RQ13) Port three bits six/seven: memory strobes
// (RQ14) Alternate function needs latch one, else zero
// (RQ15) Enabled peripheral takes over its pin
// (RQ16) Port reads return pin levels
`timescale 1ns/1ns
`include "fpio_consts.svh"

module fpio_ports
    import fpio_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        sys_rst_in,
    // Special function bus
    input  wire logic [7:0]  sfr_addr_in,
    input  wire logic        sfr_wr_in,
    input  wire logic        sfr_rd_in,
    input  wire logic [7:0]  sfr_wdata_in,
    output logic      [7:0]  sfr_rdata_out,
    // External memory cycle from the core
    input  fpio_phase_t      xmem_phase_in,
    input  wire logic        xmem_data_space_in,
    input  wire logic [23:0] xmem_addr_in,
    input  wire logic [7:0]  xmem_wdata_in,
    output logic      [7:0]  xmem_rdata_out,
    // Port zero pins
    input  wire logic [7:0]  p0_pin_in,
    output logic      [7:0]  p0_pin_out,
    output logic      [7:0]  p0_pin_oe_out,
    // Port one pins
    input  wire logic [7:0]  p1_pin_in,
    output logic      [7:0]  analog_sel_out,
    // Port two pins
    input  wire logic [7:0]  p2_pin_in,
    output logic      [7:0]  p2_pin_out,
    output logic      [7:0]  p2_pin_oe_out,
    // Port three pins
    input  wire logic [7:0]  p3_pin_in,
    output logic      [7:0]  p3_pin_out,
    output logic      [7:0]  p3_pin_oe_out,
    // Peripheral side of the port three pins
    input  wire logic [7:0]  p3_alt_en_in,
    input  wire logic [7:0]  p3_alt_value_in,
    // Alternate inputs delivered to peripherals
    output logic             timer_two_count_input_out,
    output logic             timer_two_trigger_input_out,
    output logic             spi_sel_n_out,
    output logic             uart_rx_out,
    output logic             external_interrupt_zero_out,
    output logic             external_interrupt_one_out,
    output logic             timer_zero_count_input_out,
    output logic             timer_one_count_input_out
);

    ////////////////////////////////////////////////////////////////////////
    // Latches

    localparam logic [7:0] LATCH_ADDR [4] = '{
        `FPIO_ADDR_PORT_ZERO, `FPIO_ADDR_PORT_ONE,
        `FPIO_ADDR_PORT_TWO,  `FPIO_ADDR_PORT_THREE};
    localparam logic [7:0] LATCH_RST [4] = '{
        `FPIO_RST_PORT_ZERO, `FPIO_RST_PORT_ONE,
        `FPIO_RST_PORT_TWO,  `FPIO_RST_PORT_THREE};

    logic [7:0] latch [4];

    // One latch per port at its own address [RQ1] [RQ5] [RQ8] [RQ10]
    for (genvar g = 0; g < 4; g++) begin : g_latch
        fpio_latch8 #(
            .ADDR      (LATCH_ADDR[g]),
            .RST_VALUE (LATCH_RST[g])
        ) u_latch (
            .ref_clk_in   (ref_clk_in),
            .sys_rst_in   (sys_rst_in),
            .sfr_addr_in  (sfr_addr_in),
            .sfr_wr_in    (sfr_wr_in),
            .sfr_wdata_in (sfr_wdata_in),
            .latch_out    (latch[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    fpio_state_t state_reg;
    fpio_state_t state_next;
    logic [7:0]  p3_level;
    logic [7:0]  p1_alt;
    logic [7:0]  p3_alt;

    always_comb begin
        state_next = state_reg;

        // Port zero: drive low only, float on a one [RQ1] [RQ2]
        state_next.p0_out = 8'h00;
        state_next.p0_oe  = ~latch[0];
        state_next.p0_rdata = state_reg.p0_rdata;
        case (xmem_phase_in)
            FPIO_PH_ADDR: begin
                // Low address byte, ones driven hard [RQ3] [RQ4]
                state_next.p0_out = xmem_addr_in[7:0];
                state_next.p0_oe  = 8'hFF;
            end
            FPIO_PH_WDATA: begin
                state_next.p0_out = xmem_wdata_in; // [RQ3] [RQ4]
                state_next.p0_oe  = 8'hFF;
            end
            FPIO_PH_RDATA: begin
                // Released so the memory can drive the data byte [RQ3]
                state_next.p0_out   = 8'h00;
                state_next.p0_oe    = 8'h00;
                state_next.p0_rdata = p0_pin_in;
            end
            FPIO_PH_IDLE: begin
                state_next.p0_out = 8'h00;
            end
            default: begin
                state_next.p0_oe = ~latch[0];
            end
        endcase

        // Port one has no driver; the latch picks analog or digital and gates the alternate inputs
        state_next.analog_sel = latch[1]; // [RQ5] [RQ6]

        // Port two: pull-up holds a one, so only zeros are driven [RQ8]
        state_next.p2_out = 8'h00;
        state_next.p2_oe  = ~latch[2];
        if (xmem_phase_in != FPIO_PH_IDLE) begin
            // Program space: high byte; data space: middle, then high [RQ9]
            if (!xmem_data_space_in) begin
                state_next.p2_out = xmem_addr_in[15:8];
            end else if (xmem_phase_in == FPIO_PH_ADDR) begin
                state_next.p2_out = xmem_addr_in[15:8];
            end else begin
                state_next.p2_out = xmem_addr_in[23:16];
            end
            state_next.p2_oe = 8'hFF;
        end

        // Port three: enabled peripheral owns the pin, gated by latch
        p3_level = latch[3] & ((p3_alt_en_in & p3_alt_value_in) | ~p3_alt_en_in); // [RQ14] [RQ15]
        state_next.p3_out = 8'h00;
        state_next.p3_oe  = ~p3_level; // [RQ10] [RQ11] [RQ13]

        // Alternate inputs read as zero while the latch holds zero [RQ14]
        p1_alt = p1_pin_in & latch[1];
        p3_alt = p3_pin_in & latch[3];
        state_next.t2_count     = p1_alt[`FPIO_P1_TIMER_TWO_CNT]; // [RQ7]
        state_next.t2_trigger   = p1_alt[`FPIO_P1_TIMER_TWO_TRG]; // [RQ7]
        state_next.spi_sel_n    = p1_alt[`FPIO_P1_SPI_SEL];       // [RQ7]
        state_next.uart_rx      = p3_alt[`FPIO_P3_UART_RX];       // [RQ11]
        state_next.ext_int_zero = p3_alt[`FPIO_P3_EXT_INT_ZERO];  // [RQ12]
        state_next.ext_int_one  = p3_alt[`FPIO_P3_EXT_INT_ONE];   // [RQ12]
        state_next.t0_count     = p3_alt[`FPIO_P3_TIMER_ZERO];    // [RQ12]
        state_next.t1_count     = p3_alt[`FPIO_P3_TIMER_ONE];     // [RQ12]

        // Reads see the pins, not the latches, as the core expects
        if (sfr_rd_in) begin
            case (sfr_addr_in)
                `FPIO_ADDR_PORT_ZERO:  state_next.sfr_rdata = p0_pin_in; // [RQ16]
                `FPIO_ADDR_PORT_ONE:   state_next.sfr_rdata = p1_pin_in; // [RQ16]
                `FPIO_ADDR_PORT_TWO:   state_next.sfr_rdata = p2_pin_in; // [RQ16]
                `FPIO_ADDR_PORT_THREE: state_next.sfr_rdata = p3_pin_in; // [RQ16]
                default:               state_next.sfr_rdata = `FPIO_RDATA_NONE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    // Pins come out one cycle after the latch; keeps every output registered
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state_reg            <= '0;
            state_reg.analog_sel <= `FPIO_RST_PORT_ONE; // [RQ6]
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign sfr_rdata_out               = state_reg.sfr_rdata;
    assign xmem_rdata_out              = state_reg.p0_rdata;
    assign p0_pin_out                  = state_reg.p0_out;
    assign p0_pin_oe_out               = state_reg.p0_oe;
    assign analog_sel_out              = state_reg.analog_sel;
    assign p2_pin_out                  = state_reg.p2_out;
    assign p2_pin_oe_out               = state_reg.p2_oe;
    assign p3_pin_out                  = state_reg.p3_out;
    assign p3_pin_oe_out               = state_reg.p3_oe;
    assign timer_two_count_input_out   = state_reg.t2_count;
    assign timer_two_trigger_input_out = state_reg.t2_trigger;
    assign spi_sel_n_out               = state_reg.spi_sel_n;
    assign uart_rx_out                 = state_reg.uart_rx;
    assign external_interrupt_zero_out = state_reg.ext_int_zero;
    assign external_interrupt_one_out  = state_reg.ext_int_one;
    assign timer_zero_count_input_out  = state_reg.t0_count;
    assign timer_one_count_input_out   = state_reg.t1_count;

endmodule : fpio_ports

// >>> verif/fpio_pin_world.sv
/* Pins outside the block: pull-ups and external drivers of ports zero and three.
   Assumes the bench sets which pins the outside world drives. */
`timescale 1ns/1ns
module fpio_pin_world (
    // Block drivers
    input  wire logic [7:0] p0_drv_in,
    input  wire logic [7:0] p0_oe_in,
    input  wire logic [7:0] p2_drv_in,
    input  wire logic [7:0] p2_oe_in,
    input  wire logic [7:0] p3_drv_in,
    input  wire logic [7:0] p3_oe_in,
    // Outside drivers
    input  wire logic [7:0] x0_en_in,
    input  wire logic [7:0] x0_val_in,
    input  wire logic [7:0] x3_en_in,
    input  wire logic [7:0] x3_val_in,
    // Resolved levels
    output logic      [7:0] p0_level_out,
    output logic      [7:0] p2_level_out,
    output logic      [7:0] p3_level_out
);
    // Floating pins settle to the pull-up, never to a stale value
    assign p0_level_out = (p0_oe_in & p0_drv_in) | (~p0_oe_in & (~x0_en_in | x0_val_in));
    assign p2_level_out = (p2_oe_in & p2_drv_in) | ~p2_oe_in;
    assign p3_level_out = (p3_oe_in & p3_drv_in) | (~p3_oe_in & (~x3_en_in | x3_val_in));
endmodule : fpio_pin_world

// >>> verif/fpio_ports_props.sv
/* Checker of the port block: memory bus muxing, open drain, takeover, reads.
   Assumes binding to fpio_ports, one clock, synchronous reset. */
`timescale 1ns/1ns
module fpio_ports_props
    import fpio_pkg::*;
(
    // Clock, reset and register reads
    input  wire logic        ref_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [7:0]  sfr_addr_in,
    input  wire logic        sfr_rd_in,
    input  wire logic [7:0]  sfr_rdata_out,
    // Memory cycle
    input  fpio_phase_t      xmem_phase_in,
    input  wire logic        xmem_data_space_in,
    input  wire logic [23:0] xmem_addr_in,
    input  wire logic [7:0]  xmem_wdata_in,
    // Pins
    input  wire logic [7:0]  p0_pin_out,
    input  wire logic [7:0]  p0_pin_oe_out,
    input  wire logic [7:0]  p2_pin_out,
    input  wire logic [7:0]  p3_pin_in,
    input  wire logic [7:0]  p3_pin_oe_out,
    input  wire logic [7:0]  p3_alt_en_in,
    input  wire logic [7:0]  p3_alt_value_in,
    input  wire logic        external_interrupt_zero_out
);
default clocking @(posedge ref_clk_in); endclocking
default disable iff (sys_rst_in);
bus_addr_a: assert property (xmem_phase_in == FPIO_PH_ADDR |=> p0_pin_oe_out == 8'hFF &&
    p0_pin_out == $past(xmem_addr_in[7:0]) && p2_pin_out == $past(xmem_addr_in[15:8])) else $error("bad address phase");
wdata_drive_a: assert property (xmem_phase_in == FPIO_PH_WDATA |=>
    p0_pin_out == $past(xmem_wdata_in) && p0_pin_oe_out == 8'hFF) else $error("bad write data phase");
high_byte_a: assert property (xmem_phase_in inside {FPIO_PH_WDATA, FPIO_PH_RDATA} && xmem_data_space_in
    |=> p2_pin_out == $past(xmem_addr_in[23:16])) else $error("bad high address byte");
fetch_byte_a: assert property (xmem_phase_in != FPIO_PH_IDLE && !xmem_data_space_in
    |=> p2_pin_out == $past(xmem_addr_in[15:8])) else $error("bad fetch address byte");
open_drain_a: assert property (xmem_phase_in == FPIO_PH_IDLE |=> (p0_pin_out & p0_pin_oe_out) == 8'h00)
    else $error("port zero drove a one");
strobe_take_a: assert property (p3_alt_en_in[6] && !p3_alt_value_in[6] |=> p3_pin_oe_out[6])
    else $error("write strobe not driven");
stuck_low_a: assert property (!p3_pin_in[2] |=> !external_interrupt_zero_out)
    else $error("interrupt input not low");
pin_read_a: assert property (sfr_rd_in && sfr_addr_in == 8'hB0 |=> sfr_rdata_out == $past(p3_pin_in))
    else $error("port read not pin level");
endmodule : fpio_ports_props
bind fpio_ports fpio_ports_props u_props (.ref_clk_in, .sys_rst_in, .sfr_addr_in, .sfr_rd_in, .sfr_rdata_out,
    .xmem_phase_in, .xmem_data_space_in, .xmem_addr_in, .xmem_wdata_in, .p0_pin_out, .p0_pin_oe_out,
    .p2_pin_out, .p3_pin_in, .p3_pin_oe_out, .p3_alt_en_in, .p3_alt_value_in, .external_interrupt_zero_out);

// >>> verif/tb_four_port_parallel_io.sv
/* Bench of the port block: register writes and reads, alternate pins, memory bus.
   Assumes fpio_pin_world resolves the pins. */
`timescale 1ns/1ns
module tb_four_port_parallel_io;
    import fpio_pkg::*;
    logic        ref_clk_in, sys_rst_in, sfr_wr_in, sfr_rd_in, xmem_data_space_in;
    logic [7:0]  sfr_addr_in, sfr_wdata_in, sfr_rdata_out, xmem_wdata_in, xmem_rdata_out, q;
    logic [23:0] xmem_addr_in;
    fpio_phase_t xmem_phase_in;
    logic [7:0]  p0_pin_in, p0_pin_out, p0_pin_oe_out, p1_pin_in, analog_sel_out, p2_pin_in, p2_pin_out;
    logic [7:0]  p2_pin_oe_out, p3_pin_in, p3_pin_out, p3_pin_oe_out, p3_alt_en_in, p3_alt_value_in;
    logic [7:0]  x0_en, x0_val, x3_en, x3_val, alts;
    logic        timer_two_count_input_out, timer_two_trigger_input_out, spi_sel_n_out, uart_rx_out;
    logic        external_interrupt_zero_out, external_interrupt_one_out;
    logic        timer_zero_count_input_out, timer_one_count_input_out;
    int          num_errors, comparisons, cycles;
    fpio_ports dut (.ref_clk_in, .sys_rst_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out,
        .xmem_phase_in, .xmem_data_space_in, .xmem_addr_in, .xmem_wdata_in, .xmem_rdata_out, .p0_pin_in,
        .p0_pin_out, .p0_pin_oe_out, .p1_pin_in, .analog_sel_out, .p2_pin_in, .p2_pin_out, .p2_pin_oe_out,
        .p3_pin_in, .p3_pin_out, .p3_pin_oe_out, .p3_alt_en_in, .p3_alt_value_in, .timer_two_count_input_out,
        .timer_two_trigger_input_out, .spi_sel_n_out, .uart_rx_out, .external_interrupt_zero_out,
        .external_interrupt_one_out, .timer_zero_count_input_out, .timer_one_count_input_out);
    fpio_pin_world u_world (.p0_drv_in(p0_pin_out), .p0_oe_in(p0_pin_oe_out), .p2_drv_in(p2_pin_out),
        .p2_oe_in(p2_pin_oe_out), .p3_drv_in(p3_pin_out), .p3_oe_in(p3_pin_oe_out), .x0_en_in(x0_en),
        .x0_val_in(x0_val), .x3_en_in(x3_en), .x3_val_in(x3_val), .p0_level_out(p0_pin_in),
        .p2_level_out(p2_pin_in), .p3_level_out(p3_pin_in));
    assign alts = {timer_two_count_input_out, timer_two_trigger_input_out, spi_sel_n_out, uart_rx_out,
        external_interrupt_zero_out, external_interrupt_one_out, timer_zero_count_input_out,
        timer_one_count_input_out};
    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task results;
        $display("comparisons=%0d mismatches=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    // Outputs are levels, so three edges always cover the two-cycle path
    task settle;
        repeat (3) @(posedge ref_clk_in);
        #1;
    endtask : settle
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        sfr_addr_in <= a;
        sfr_wdata_in <= d;
        sfr_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        sfr_wr_in <= 1'b0;
        settle;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge ref_clk_in);
        sfr_addr_in <= a;
        sfr_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        sfr_rd_in <= 1'b0;
        @(posedge ref_clk_in);
        #1 q = sfr_rdata_out;
    endtask : rd
    task mem(input fpio_phase_t ph, input logic ds);
        @(posedge ref_clk_in);
        xmem_phase_in <= ph;
        xmem_data_space_in <= ds;
        settle;
    endtask : mem
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors++;
            results;
        end
    end
    initial begin
        {sfr_wr_in, sfr_rd_in, xmem_data_space_in, sfr_addr_in, sfr_wdata_in, xmem_wdata_in} = '0;
        {xmem_addr_in, p3_alt_en_in, p3_alt_value_in, x0_en, x0_val, x3_en, x3_val} = '0;
        {num_errors, comparisons, cycles} = '0;
        xmem_phase_in = FPIO_PH_IDLE;
        p1_pin_in = 8'hA5;
        sys_rst_in = 1'b1;
        repeat (16) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        settle;
        check(analog_sel_out, 8'hFF);
        check({p0_pin_oe_out, p2_pin_oe_out, p3_pin_oe_out}, 24'h0);
        rd(8'h90);
        check(q, 8'hA5);
        rd(8'h85);
        check(q, 8'h00);
        $display("test reset done");
        wr(8'h80, 8'h00);
        wr(8'h90, 8'h00);
        wr(8'hA0, 8'h00);
        wr(8'hB0, 8'h00);
        @(posedge ref_clk_in);
        p1_pin_in <= 8'hFF;
        settle;
        check({p0_pin_oe_out, p2_pin_oe_out, p3_pin_oe_out}, 24'hFFFFFF);
        check({p0_pin_out, p2_pin_out, p3_pin_out, analog_sel_out}, 32'h0);
        check(alts, 8'h00);
        rd(8'hB0);
        check(q, 8'h00);
        wr(8'h90, 8'hFF);
        wr(8'hB0, 8'hFF);
        // Last pattern mixes ones and zeros (BAh on the alternate inputs) so a swapped pin shows up
        for (int v = 0; v < 3; v++) begin
            @(posedge ref_clk_in);
            x3_en <= 8'hFF;
            x3_val <= (v == 2) ? 8'h15 : (v ? 8'h3D : 8'h00);
            p1_pin_in <= (v == 2) ? 8'h21 : (v ? 8'hFF : 8'h00);
            settle;
            check(alts, (v == 2) ? 8'hBA : (v ? 8'hFF : 8'h00));
        end
        $display("test alternate inputs done");
        @(posedge ref_clk_in);
        x3_en <= 8'h00;
        p3_alt_en_in <= 8'hC2;
        settle;
        check(p3_pin_oe_out, 8'hC2);
        @(posedge ref_clk_in);
        p3_alt_value_in <= 8'hC2;
        settle;
        check(p3_pin_oe_out, 8'h00);
        $display("test takeover done");
        wr(8'h80, 8'hFF);
        @(posedge ref_clk_in);
        xmem_addr_in <= 24'h123456;
        xmem_wdata_in <= 8'hA5;
        x0_val <= 8'h3C;
        mem(FPIO_PH_ADDR, 1'b1);
        check({p2_pin_out, p0_pin_out, p0_pin_oe_out}, 24'h3456FF);
        mem(FPIO_PH_WDATA, 1'b1);
        check({p2_pin_out, p0_pin_out, p0_pin_oe_out}, 24'h12A5FF);
        @(posedge ref_clk_in);
        x0_en <= 8'hFF;
        mem(FPIO_PH_RDATA, 1'b1);
        check({p2_pin_out, p0_pin_oe_out, xmem_rdata_out}, 24'h12003C);
        mem(FPIO_PH_RDATA, 1'b0);
        check(p2_pin_out, 8'h34);
        @(posedge ref_clk_in);
        x0_en <= 8'h00;
        mem(FPIO_PH_IDLE, 1'b0);
        check({p0_pin_oe_out, p2_pin_out, p2_pin_oe_out}, 24'h0000FF);
        $display("test memory bus done");
        results;
    end
endmodule : tb_four_port_parallel_io
